// file: logic/phase_sync_cfg.svh
// Constants for the multi-unit phase synchronisation control
// Operation
// - Bit 6 of flag word enables synchronous mode
// - Bit 7 of flag word selects master unit
// - Set-function command replaces whole flag word
// - Missing shared clock or realign raises error
// - Read-function command returns current flag word
// - Shared lines used only with synchronous mode, except the clock watchdog, which also runs with the master bit alone
// - Master realign command emits shared realign pulse
// - Recalled slave unaligned until next realign pulse
// - Up to eight units, sixteen channels
// - Master drives clock, realign; uses loopback inputs
// - Input clock latches samples; slave outputs unused
`ifndef PHASE_SYNC_CFG_SVH
`define PHASE_SYNC_CFG_SVH
`define FLAG_W 16
`define FLAG_RESET 16'h0000
`define SYNC_EN_BIT 6
`define MASTER_BIT 7
`define NUM_CHANNELS 2
`define MAX_UNITS 8
`define PHASE_W 32
`define CLK_PERIOD_NS 5
`define SCLK_HALF_NS 30
`define SCLK_HALF_CYC (`SCLK_HALF_NS / `CLK_PERIOD_NS)
`define CLK_LOSS_NS 1000
`define CLK_LOSS_CYC (`CLK_LOSS_NS / `CLK_PERIOD_NS)
`define RLN_LOSS_NS 1000
`define RLN_LOSS_CYC (`RLN_LOSS_NS / `CLK_PERIOD_NS)
`define CNT_W 16
`endif

// file: logic/phase_sync_pkg.sv
// Types for the multi-unit phase synchronisation control
package phase_sync_pkg;
   typedef enum logic [1:0] {
      set_function_cmd,
      read_function_cmd,
      phase_realign_cmd,
      preset_cmd
   } cmd_code_t;
   typedef enum logic [1:0] {
      rln_idle,
      rln_armed,
      rln_pulse
   } realign_state_t;
endpackage

// file: logic/pin_edge_sync.sv
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
module pin_edge_sync (
   input wire logic clock_i, // System clock
   input wire logic rstn_i,  // Async reset, active low
   input wire logic pin_i,   // Asynchronous pin
   output logic level_o,     // Synchronised level
   output logic rise_o       // One-cycle rising edge pulse
);
   logic meta;
   logic stable;
   logic last;

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta <= 1'b0;
         stable <= 1'b0;
         last <= 1'b0;
      end
      else
      begin
         meta <= pin_i;
         stable <= meta;
         last <= stable;
      end
   end

   assign level_o = stable;
   assign rise_o = stable & ~last;
endmodule

// file: logic/phase_sync_ctrl.sv
// Flag word, master timing, realign and channel phase control
`timescale 1ns/1ps
`include "phase_sync_cfg.svh"
module phase_sync_ctrl
   import phase_sync_pkg::*;
(
   input wire logic clock_i,                            // 200 MHz clock
   input wire logic rstn_i,                             // Async reset, active low
   input wire logic cmd_valid_i,                        // Command strobe
   input wire cmd_code_t cmd_code_i,                    // Command code
   input wire logic [`FLAG_W-1:0] cmd_arg_i,            // Set-function argument
   output logic resp_valid_o,                           // Read reply strobe
   output logic [`FLAG_W-1:0] resp_data_o,              // Read reply flag word
   input wire logic sync_clk_i,                         // Shared clock pin in
   input wire logic realign_i,                          // Shared realign pin in
   output logic sync_clk_o,                             // Shared clock pin out
   output logic realign_o,                              // Shared realign pin out
   input wire logic [`PHASE_W-1:0] freq_word_i [`NUM_CHANNELS], // Phase steps
   input wire logic [`PHASE_W-1:0] phase_ofs_i [`NUM_CHANNELS], // Phase offsets
   output logic [`PHASE_W-1:0] phase_o [`NUM_CHANNELS], // Accumulators
   output logic sample_o,                               // Sample latch pulse
   output logic sync_mode_o,                            // Synchronous mode on
   output logic master_mode_o,                          // Master selected
   output logic aligned_o,                              // Aligned since realign
   output logic error_o                                 // Missing shared signal
);
   localparam int EMIT_MAX = 2 * `SCLK_HALF_CYC + 2;

   logic [`FLAG_W-1:0] flags;
   logic sync_en;
   logic master;
   logic drive_en;
   logic set_cmd;
   logic clr_cmd;
   logic rln_cmd;
   logic clk_lvl;
   logic clk_rise;
   logic rln_lvl;
   logic [`CNT_W-1:0] half_cnt;
   logic gen_clk;
   logic half_wrap;
   logic gen_fall;
   logic gen_rise;
   realign_state_t rln_state;
   logic local_rln;
   logic tick;
   logic load;
   logic [`CNT_W-1:0] clk_wd;
   logic [`CNT_W-1:0] rln_wd;
   logic rln_wait;
   logic clk_lost;
   logic rln_lost;

   // ***************************************
   // Command decode and flag word
   // ***************************************
   assign set_cmd = cmd_valid_i && cmd_code_i == set_function_cmd;
   assign clr_cmd = cmd_valid_i && (cmd_code_i == set_function_cmd || cmd_code_i == preset_cmd);
   assign rln_cmd = cmd_valid_i && cmd_code_i == phase_realign_cmd;
   assign sync_en = flags[`SYNC_EN_BIT];
   assign master = flags[`MASTER_BIT];
   assign drive_en = sync_en && master;
   assign sync_mode_o = sync_en;
   assign master_mode_o = master;

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         flags <= `FLAG_RESET;
      else if (set_cmd)
         flags <= cmd_arg_i;
      else if (cmd_valid_i && cmd_code_i == preset_cmd)
         flags <= `FLAG_RESET;
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         resp_valid_o <= 1'b0;
         resp_data_o <= `FLAG_RESET;
      end
      else
      begin
         resp_valid_o <= cmd_valid_i && cmd_code_i == read_function_cmd;
         if (cmd_valid_i && cmd_code_i == read_function_cmd)
            resp_data_o <= flags;
      end
   end

   // ***************************************
   // Shared pin inputs
   // ***************************************
   pin_edge_sync u_clk_sync (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .pin_i(sync_clk_i),
      .level_o(clk_lvl),
      .rise_o(clk_rise)
   );

   pin_edge_sync u_rln_sync (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .pin_i(realign_i),
      .level_o(rln_lvl),
      .rise_o()
   );

   // ***************************************
   // Internal sample clock divider
   // ***************************************
   assign half_wrap = half_cnt == `CNT_W'(`SCLK_HALF_CYC - 1);
   assign gen_fall = half_wrap && gen_clk;
   assign gen_rise = half_wrap && !gen_clk;

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         half_cnt <= '0;
         gen_clk <= 1'b0;
      end
      else if (half_wrap)
      begin
         half_cnt <= '0;
         gen_clk <= ~gen_clk;
      end
      else
         half_cnt <= half_cnt + 1'b1;
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         sync_clk_o <= 1'b0;
      else
         sync_clk_o <= drive_en && gen_clk;
   end

   // ***************************************
   // Realign pulse emitter
   // ***************************************
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rln_state <= rln_idle;
         realign_o <= 1'b0;
      end
      else if (!drive_en)
      begin
         rln_state <= rln_idle;
         realign_o <= 1'b0;
      end
      else
      begin
         case (rln_state)
            rln_idle:
               if (rln_cmd)
                  rln_state <= rln_armed;
            rln_armed:
               if (gen_fall)
               begin
                  rln_state <= rln_pulse;
                  realign_o <= 1'b1;
               end
            rln_pulse:
               if (gen_fall)
               begin
                  rln_state <= rln_idle;
                  realign_o <= 1'b0;
               end
            default:
               rln_state <= rln_idle;
         endcase
      end
   end

   // Free-running mode takes a realign command locally
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         local_rln <= 1'b0;
      else if (rln_cmd && !sync_en)
         local_rln <= 1'b1;
      else if (tick)
         local_rln <= 1'b0;
   end

   // ***************************************
   // Sample tick and channel accumulators
   // ***************************************
   assign tick = sync_en ? clk_rise : gen_rise;
   assign load = sync_en ? rln_lvl : local_rln;
   assign sample_o = tick;

   generate
      for (genvar ch = 0; ch < `NUM_CHANNELS; ch++)
      begin : g_chan
         always_ff @(posedge clock_i or negedge rstn_i)
         begin
            if (!rstn_i)
               phase_o[ch] <= '0;
            else if (tick && load)
               phase_o[ch] <= phase_ofs_i[ch];
            else if (tick)
               phase_o[ch] <= phase_o[ch] + freq_word_i[ch];
         end
      end
   endgenerate

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         aligned_o <= 1'b0;
      else if (tick && load)
         aligned_o <= 1'b1;
      else if (clr_cmd)
         aligned_o <= 1'b0;
   end

   // ***************************************
   // Missing shared signal detection
   // ***************************************
   assign clk_lost = clk_wd == `CNT_W'(`CLK_LOSS_CYC);
   assign rln_lost = rln_wd == `CNT_W'(`RLN_LOSS_CYC);

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         clk_wd <= '0;
      else if (!(sync_en || master) || clk_rise)
         clk_wd <= '0;
      else if (!clk_lost)
         clk_wd <= clk_wd + 1'b1;
   end

   // Master expects its own realign back on the loop
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rln_wait <= 1'b0;
         rln_wd <= '0;
      end
      else if (realign_o && drive_en)
      begin
         rln_wait <= 1'b1;
         rln_wd <= '0;
      end
      else if (rln_lvl || !rln_wait)
         rln_wait <= 1'b0;
      else if (!rln_lost)
         rln_wd <= rln_wd + 1'b1;
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         error_o <= 1'b0;
      else if (clk_lost || (rln_wait && rln_lost))
         error_o <= 1'b1;
      else if (clr_cmd)
         error_o <= 1'b0;
   end

   // ***************************************
   // Assertions
   // ***************************************
   a_set_replaces: assert property (@(posedge clock_i) disable iff (!rstn_i)
      set_cmd |=> flags == $past(cmd_arg_i))
      else $error("flag word not replaced by set command");

   a_sync_bit: assert property (@(posedge clock_i) disable iff (!rstn_i)
      set_cmd |=> sync_mode_o == $past(cmd_arg_i[`SYNC_EN_BIT]))
      else $error("sync mode bit mismatch");

   a_master_bit: assert property (@(posedge clock_i) disable iff (!rstn_i)
      set_cmd |=> master_mode_o == $past(cmd_arg_i[`MASTER_BIT]))
      else $error("master bit mismatch");

   a_read_reply: assert property (@(posedge clock_i) disable iff (!rstn_i)
      cmd_valid_i && cmd_code_i == read_function_cmd
      |=> resp_valid_o && resp_data_o == $past(flags))
      else $error("read reply wrong");

   a_realign_emit: assert property (@(posedge clock_i) disable iff (!rstn_i)
      rln_cmd && drive_en && rln_state == rln_idle && !set_cmd && !clr_cmd
      |-> ##[1:EMIT_MAX] (realign_o || !drive_en))
      else $error("realign pulse not emitted");

   a_slave_quiet: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !drive_en ##1 !drive_en |-> !sync_clk_o && !realign_o)
      else $error("slave drives shared outputs");

   a_phase_load: assert property (@(posedge clock_i) disable iff (!rstn_i)
      tick && load |=> phase_o[0] == $past(phase_ofs_i[0]) && aligned_o)
      else $error("phase offset not loaded");

   a_clk_loss: assert property (@(posedge clock_i) disable iff (!rstn_i)
      clk_lost |=> error_o)
      else $error("missing clock not flagged");

   a_align_clear: assert property (@(posedge clock_i) disable iff (!rstn_i)
      clr_cmd && !(tick && load) |=> !aligned_o)
      else $error("alignment kept after settings change");

   c_realign: cover property (@(posedge clock_i) disable iff (!rstn_i)
      realign_o ##[1:EMIT_MAX] (tick && load));
   c_read: cover property (@(posedge clock_i) disable iff (!rstn_i)
      resp_valid_o && resp_data_o[`MASTER_BIT]);
   c_error: cover property (@(posedge clock_i) disable iff (!rstn_i)
      sync_en && error_o);
endmodule

// file: bench/sync_link_model.sv
// Far-side model: loopback cabling or an external master on the shared lines
`timescale 1ns/1ps
module sync_link_model (
   input wire logic loop_i,    // Loop device outputs back
   input wire logic run_i,     // External link clock running
   input wire logic pulse_i,   // External realign request
   input wire logic dev_clk_i, // Device shared clock out
   input wire logic dev_rln_i, // Device realign out
   output logic clk_o,         // Shared clock to device
   output logic rln_o          // Shared realign to device
);
   logic ext_clk = 1'b0;
   logic ext_rln = 1'b0;
   // Link clock stands still between frames
   always #32 ext_clk = run_i ? ~ext_clk : 1'b0;
   // Realign held over four link clock rises
   always @(posedge pulse_i)
   begin
      ext_rln = 1'b1;
      repeat (4) @(posedge ext_clk);
      ext_rln = 1'b0;
   end
   assign clk_o = loop_i ? dev_clk_i : ext_clk;
   assign rln_o = loop_i ? dev_rln_i : ext_rln;
endmodule

// file: bench/tb_multi_unit_phase_sync_control.sv
// Testbench for the phase synchronisation control
`timescale 1ns/1ps
`include "phase_sync_cfg.svh"
module tb_multi_unit_phase_sync_control
   import phase_sync_pkg::*;
;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   cmd_code_t cmd_code_i = set_function_cmd;
   logic [`FLAG_W-1:0] cmd_arg_i = 16'h0000;
   logic resp_valid_o, sync_clk_o, realign_o, sample_o, sync_mode_o, master_mode_o;
   logic aligned_o, error_o, lnk_clk, lnk_rln;
   logic [`FLAG_W-1:0] resp_data_o;
   logic [`PHASE_W-1:0] freq_w [`NUM_CHANNELS];
   logic [`PHASE_W-1:0] ofs_w [`NUM_CHANNELS];
   logic [`PHASE_W-1:0] phase_o [`NUM_CHANNELS];
   logic loop = 1'b0;
   logic run = 1'b0;
   logic pulse = 1'b0;
   int n_mismatch = 0;
   int n_compared = 0;
   int n;

   always #2.5 clock_i = ~clock_i;

   phase_sync_ctrl dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
      .cmd_code_i(cmd_code_i), .cmd_arg_i(cmd_arg_i), .resp_valid_o(resp_valid_o),
      .resp_data_o(resp_data_o), .sync_clk_i(lnk_clk), .realign_i(lnk_rln),
      .sync_clk_o(sync_clk_o), .realign_o(realign_o), .freq_word_i(freq_w),
      .phase_ofs_i(ofs_w), .phase_o(phase_o), .sample_o(sample_o),
      .sync_mode_o(sync_mode_o), .master_mode_o(master_mode_o), .aligned_o(aligned_o),
      .error_o(error_o));

   sync_link_model link_u (.loop_i(loop), .run_i(run), .pulse_i(pulse),
      .dev_clk_i(sync_clk_o), .dev_rln_i(realign_o), .clk_o(lnk_clk), .rln_o(lnk_rln));

   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic fail(input string m);
      n_mismatch++;
      $display("ERROR at %0t ns: %s", $time, m);
   endtask
   task automatic chk_bit(input logic g, input logic e, input string m);
      n_compared++;
      if (g !== e) fail(m);
   endtask
   task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string m);
      n_compared++;
      if (g !== e) fail(m);
   endtask
   task automatic chk_phase(input logic [31:0] g, input logic [31:0] e, input string m);
      n_compared++;
      if (g !== e) fail(m);
   endtask
   task automatic send(input cmd_code_t c, input logic [15:0] a);
      @(posedge clock_i);
      #1;
      cmd_valid_i = 1'b1;
      cmd_code_i = c;
      cmd_arg_i = a;
      @(posedge clock_i);
      #1;
      cmd_valid_i = 1'b0;
   endtask
   task automatic read_chk(input logic [15:0] e);
      send(read_function_cmd, 16'h0000);
      chk_bit(resp_valid_o, 1'b1, "no read reply");
      chk_word(resp_data_o, e, "read flag word");
      wait_cyc(1);
      chk_bit(resp_valid_o, 1'b0, "read reply longer than one cycle");
   endtask
   task automatic wait_cyc(input int k);
      repeat (k) @(posedge clock_i);
      #1;
   endtask
   task automatic wait_rise(ref logic s, input int lim);
      repeat (lim)
      begin
         @(posedge clock_i);
         #1;
         if (s === 1'b1) break;
      end
   endtask
   task automatic count_rises(output int c);
      logic p;
      c = 0;
      p = sync_clk_o;
      repeat (60)
      begin
         @(posedge clock_i);
         #1;
         if (sync_clk_o === 1'b1 && p === 1'b0) c++;
         p = sync_clk_o;
      end
   endtask
   task automatic chk_loaded;
      wait_cyc(1);
      for (int i = 0; i < `NUM_CHANNELS; i++)
         chk_phase(phase_o[i], ofs_w[i], "phase not loaded");
   endtask
   task automatic report_and_stop;
      $display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial
   begin
      freq_w[0] = 32'h0000_1000;
      freq_w[1] = 32'h0100_0000;
      ofs_w[0] = 32'h1234_5678;
      ofs_w[1] = 32'h8000_0000;
      repeat (6) @(posedge clock_i);
      #1;
      rstn_i = 1'b1;
      read_chk(16'h0000);
      // Free-running unit realigns locally on its next internal tick
      send(phase_realign_cmd, 16'h0000);
      wait_rise(aligned_o, 20);
      chk_bit(aligned_o, 1'b1, "local realign missing");
      chk_loaded();
      send(set_function_cmd, 16'h0040);
      chk_bit(sync_mode_o, 1'b1, "sync bit");
      chk_bit(master_mode_o, 1'b0, "master bit");
      chk_bit(aligned_o, 1'b0, "aligned kept after set");
      read_chk(16'h0040);
      wait_cyc(250);
      chk_bit(error_o, 1'b1, "no error without link");
      send(set_function_cmd, 16'h0080);
      chk_bit(sync_mode_o, 1'b0, "sync kept");
      chk_bit(master_mode_o, 1'b1, "master bit not set");
      read_chk(16'h0080);
      send(set_function_cmd, 16'hffff);
      read_chk(16'hffff);
      send(preset_cmd, 16'h0000);
      read_chk(16'h0000);
      // Slave fed by an external master
      run = 1'b1;
      wait_cyc(20);
      send(set_function_cmd, 16'h0040);
      wait_cyc(250);
      chk_bit(error_o, 1'b0, "error with link");
      chk_bit(aligned_o, 1'b0, "aligned early");
      count_rises(n);
      chk_word(n[15:0], 16'h0000, "slave clock out moves");
      pulse = 1'b1;
      wait_rise(aligned_o, 100);
      chk_bit(aligned_o, 1'b1, "slave not aligned");
      chk_loaded();
      // Master with outputs looped back
      pulse = 1'b0;
      run = 1'b0;
      loop = 1'b1;
      send(set_function_cmd, 16'h00c0);
      read_chk(16'h00c0);
      chk_bit(aligned_o, 1'b0, "aligned kept");
      count_rises(n);
      chk_word(n[15:0], 16'h0005, "master clock rate");
      send(phase_realign_cmd, 16'h0000);
      wait_rise(realign_o, 14);
      chk_bit(realign_o, 1'b1, "no realign pulse");
      wait_rise(aligned_o, 40);
      chk_bit(aligned_o, 1'b1, "master not aligned");
      chk_loaded();
      // Next sample tick advances the accumulator by one step
      wait_rise(sample_o, 20);
      chk_bit(sample_o, 1'b1, "no sample tick");
      wait_cyc(1);
      chk_phase(phase_o[0], ofs_w[0] + freq_w[0], "phase not advanced");
      chk_phase(phase_o[1], ofs_w[1] + freq_w[1], "phase not advanced");
      wait_cyc(250);
      chk_bit(error_o, 1'b0, "loopback error");
      report_and_stop();
   end

   initial
   begin
      #50000;
      fail("watchdog expired");
      report_and_stop();
   end
endmodule
